// file: rtl/dom_access_port.sv
`timescale 1ns/10ps
`default_nettype none


module dom_access_port
  import dom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Receive line pins
  input wire logic line_rx_clock,
  input wire logic line_rx_data,
  input wire logic line_rx_neg_rail,
  // Configuration
  input wire logic cfg_rx_fall_edge,
  input wire logic cfg_rx_dual_rail,
  input wire logic cfg_tx_sync_input,
  input wire logic cfg_m13_async,
  input wire logic cfg_tx_stuff_insert,
  // Transmit overhead pins
  output logic tx_ovh_bit_clock,
  input wire logic tx_ovh_data_in,
  input wire logic tx_ovh_insert_enable,
  input wire logic tx_ovh_frame_sync_i,
  output logic tx_ovh_frame_sync_o,
  output logic tx_ovh_frame_sync_oe,
  output logic tx_stuff_bit_clock,
  input wire logic tx_stuff_bit_data,
  // Receive overhead pins
  output logic rx_ovh_bit_clock,
  output logic rx_ovh_data_out,
  output logic rx_ovh_frame_sync,
  output logic rx_stuff_bit_clock,
  output logic rx_stuff_bit_data,
  // Core transmit stream
  input wire logic tx_bit_strobe,
  input wire logic tx_bit_internal,
  output logic tx_bit_out,
  output logic tx_bit_out_valid,
  output logic tx_mframe_start,
  // Core receive stream
  output logic rx_bit_valid,
  output logic rx_bit_data,
  input wire logic rx_mframe_align,
  output logic rx_mframe_start
);

  dom_rx_bit_if rx_bits ();

  dom_rx_sampler u_rx_sampler (
    .core_clk(core_clk),
    .resetn(resetn),
    .line_rx_clock(line_rx_clock),
    .line_rx_data(line_rx_data),
    .line_rx_neg_rail(line_rx_neg_rail),
    .cfg_rx_fall_edge(cfg_rx_fall_edge),
    .cfg_rx_dual_rail(cfg_rx_dual_rail),
    .rx_bits(rx_bits.src)
  );

  // ---------------- Transmit side ----------------

  logic [3:0] tx_pin_s1_q;
  logic [3:0] tx_pin_s2_q;
  logic sync_prev_q;
  logic sync_edge;
  dom_pos_t tx_pos_q;
  dom_pos_t tx_cur;
  logic ovh_clk_q;
  logic ins_data_q;
  logic ins_en_q;
  logic sync_out_q;
  logic stuff_clk_q;
  logic stuff_data_q;
  logic tx_out_q;
  logic tx_valid_q;
  logic tx_start_q;
  logic stuff_allowed;

  // Partner pins cross into the core clock through two flops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_pin_s1_q <= 4'h0;
      tx_pin_s2_q <= 4'h0;
    end else begin
      tx_pin_s1_q <= {tx_stuff_bit_data, tx_ovh_frame_sync_i,
                      tx_ovh_insert_enable, tx_ovh_data_in};
      tx_pin_s2_q <= tx_pin_s1_q;
    end
  end

  // Sync input is seen once per transmit clock rise
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync_prev_q <= 1'b0;
    end else if (tx_bit_strobe) begin
      sync_prev_q <= tx_pin_s2_q[2];
    end
  end

  assign sync_edge = cfg_tx_sync_input & tx_pin_s2_q[2] & ~sync_prev_q;
  // An input pulse says the current bit is the first X-bit
  assign tx_cur = sync_edge ? POS_ZERO : tx_pos_q;
  assign stuff_allowed = cfg_m13_async & cfg_tx_stuff_insert;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_pos_q <= POS_ZERO;
    end else if (tx_bit_strobe) begin
      tx_pos_q <= dom_next_pos(tx_cur);
    end
  end

  // Overhead clock: falls at each overhead slot, rises mid block
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ovh_clk_q <= 1'b0;
    end else if (tx_bit_strobe) begin
      if (tx_cur.bit_n == OVH_BIT) begin
        ovh_clk_q <= 1'b0;
      end else if (tx_cur.bit_n == OVH_CLK_RISE) begin
        ovh_clk_q <= 1'b1;
      end
    end
  end

  // Bit sampled in block k fills the overhead slot of block k+1
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ins_data_q <= 1'b0;
      ins_en_q <= 1'b0;
    end else if (tx_bit_strobe && tx_cur.bit_n == OVH_CLK_RISE) begin
      ins_data_q <= tx_pin_s2_q[0];
      ins_en_q <= tx_pin_s2_q[1];
    end
  end

  // The slot due next is the first X-bit after the last block
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync_out_q <= 1'b0;
    end else if (tx_bit_strobe && tx_cur.bit_n == OVH_BIT) begin
      sync_out_q <= (tx_cur.blk == BLK_LAST) &&
                    (tx_cur.sub == SUB_LAST);
    end
  end

  // Stuff clock runs only in M13 asynchronous format
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stuff_clk_q <= 1'b0;
      stuff_data_q <= 1'b0;
    end else if (!cfg_m13_async) begin
      stuff_clk_q <= 1'b0;
    end else if (tx_bit_strobe) begin
      if (tx_cur.blk == STUFF_CLK_BLK && tx_cur.bit_n == OVH_CLK_RISE) begin
        stuff_clk_q <= 1'b1;
        stuff_data_q <= tx_pin_s2_q[3];
      end else if (tx_cur.blk == STUFF_BLK && tx_cur.bit_n == OVH_BIT) begin
        stuff_clk_q <= 1'b0;
      end
    end
  end

  // Outgoing bit with overhead and stuff replacement applied
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_out_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_start_q <= 1'b0;
    end else begin
      tx_valid_q <= tx_bit_strobe;
      if (tx_bit_strobe) begin
        tx_start_q <= dom_is_x1(tx_cur);
        if (tx_cur.bit_n == OVH_BIT && ins_en_q) begin
          tx_out_q <= ins_data_q;
        end else if (tx_cur.blk == STUFF_BLK &&
                     tx_cur.bit_n == STUFF_BIT && stuff_allowed) begin
          tx_out_q <= stuff_data_q;
        end else begin
          tx_out_q <= tx_bit_internal;
        end
      end
    end
  end

  assign tx_ovh_bit_clock = ovh_clk_q;
  assign tx_ovh_frame_sync_o = sync_out_q;
  assign tx_ovh_frame_sync_oe = ~cfg_tx_sync_input;
  assign tx_stuff_bit_clock = stuff_clk_q;
  assign tx_bit_out = tx_out_q;
  assign tx_bit_out_valid = tx_valid_q;
  assign tx_mframe_start = tx_start_q;

  // ---------------- Receive side ----------------

  dom_pos_t rx_pos_q;
  dom_pos_t rx_cur;
  logic rx_hold_q;
  logic rx_hold_x_q;
  logic rx_clk_q;
  logic rx_data_q;
  logic rx_sync_q;
  logic rx_stuff_hold_q;
  logic rx_stuff_clk_q;
  logic rx_stuff_data_q;
  logic rx_start_q;

  // Core framer flags the X-bit of the first subframe
  assign rx_cur = rx_mframe_align ? POS_ZERO : rx_pos_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_pos_q <= POS_ZERO;
    end else if (rx_bits.bit_valid) begin
      rx_pos_q <= dom_next_pos(rx_cur);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_hold_q <= 1'b0;
      rx_hold_x_q <= 1'b0;
      rx_stuff_hold_q <= 1'b0;
    end else if (rx_bits.bit_valid) begin
      if (rx_cur.bit_n == OVH_BIT) begin
        rx_hold_q <= rx_bits.bit_data;
        rx_hold_x_q <= dom_is_x1(rx_cur);
      end
      if (rx_cur.blk == STUFF_BLK && rx_cur.bit_n == STUFF_BIT) begin
        rx_stuff_hold_q <= rx_bits.bit_data;
      end
    end
  end

  // Data and sync move only when the overhead clock falls
  // Clock idles high so the first overhead slot gets a real fall
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_clk_q <= 1'b1;
      rx_data_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end else if (rx_bits.bit_valid) begin
      if (rx_cur.bit_n == RX_OVH_FALL) begin
        rx_clk_q <= 1'b0;
        rx_data_q <= rx_hold_q;
        rx_sync_q <= rx_hold_x_q;
      end else if (rx_cur.bit_n == RX_OVH_RISE) begin
        rx_clk_q <= 1'b1;
      end
    end
  end

  // Outside M13 the stuff pins are held low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_stuff_clk_q <= 1'b1;
      rx_stuff_data_q <= 1'b0;
    end else if (!cfg_m13_async) begin
      rx_stuff_clk_q <= 1'b0;
      rx_stuff_data_q <= 1'b0;
    end else if (rx_bits.bit_valid && rx_cur.blk == STUFF_BLK) begin
      if (rx_cur.bit_n == RX_STUFF_FALL) begin
        rx_stuff_clk_q <= 1'b0;
        rx_stuff_data_q <= rx_stuff_hold_q;
      end else if (rx_cur.bit_n == RX_STUFF_RISE) begin
        rx_stuff_clk_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_start_q <= 1'b0;
    end else if (rx_bits.bit_valid) begin
      rx_start_q <= dom_is_x1(rx_cur);
    end
  end

  assign rx_ovh_bit_clock = rx_clk_q;
  assign rx_ovh_data_out = rx_data_q;
  assign rx_ovh_frame_sync = rx_sync_q;
  assign rx_stuff_bit_clock = rx_stuff_clk_q;
  assign rx_stuff_bit_data = rx_stuff_data_q;
  assign rx_bit_valid = rx_bits.bit_valid;
  assign rx_bit_data = rx_bits.bit_data;
  assign rx_mframe_start = rx_start_q;

endmodule

`default_nettype wire

// file: rtl/dom_pkg.sv
package dom_pkg;

  // Line and overhead rates; one overhead bit opens every block
  localparam int LINE_RATE_KHZ = 44736;
  localparam int OVH_RATE_KHZ = 526;
  localparam int BLOCK_BITS = LINE_RATE_KHZ / OVH_RATE_KHZ;
  localparam int BLOCKS = 8;
  localparam int SUBFRAMES = 7;

  localparam logic [6:0] BIT_LAST = 7'(BLOCK_BITS - 1);
  localparam logic [2:0] BLK_LAST = 3'(BLOCKS - 1);
  localparam logic [2:0] SUB_LAST = 3'(SUBFRAMES - 1);

  // Positions within a block
  localparam logic [6:0] OVH_BIT = 7'h00;
  localparam logic [6:0] STUFF_BIT = 7'h01;
  localparam logic [6:0] OVH_CLK_RISE = 7'h2a;
  localparam logic [6:0] RX_OVH_FALL = 7'h01;
  localparam logic [6:0] RX_OVH_RISE = 7'h2b;
  localparam logic [6:0] RX_STUFF_FALL = 7'h02;
  localparam logic [6:0] RX_STUFF_RISE = 7'h2c;

  // Blocks carrying the stuff clock, the stuffed position and the X-bit; subframe of the X-bit
  localparam logic [2:0] STUFF_CLK_BLK = 3'h6;
  localparam logic [2:0] STUFF_BLK = 3'h7;
  localparam logic [2:0] X_BLK = 3'h0;
  localparam logic [2:0] X_SUB = 3'h0;

  typedef struct packed {
    logic [2:0] sub;
    logic [2:0] blk;
    logic [6:0] bit_n;
  } dom_pos_t;

  localparam dom_pos_t POS_ZERO = '0;

  function automatic dom_pos_t dom_next_pos(input dom_pos_t p);
    dom_pos_t n;
    n = p;
    if (p.bit_n != BIT_LAST) begin
      n.bit_n = p.bit_n + 7'h01;
    end else begin
      n.bit_n = OVH_BIT;
      if (p.blk != BLK_LAST) begin
        n.blk = p.blk + 3'h1;
      end else begin
        n.blk = 3'h0;
        n.sub = (p.sub == SUB_LAST) ? 3'h0 : p.sub + 3'h1;
      end
    end
    return n;
  endfunction

  // X-bit of the first subframe
  function automatic logic dom_is_x1(input dom_pos_t p);
    return (p.sub == X_SUB) && (p.blk == X_BLK) && (p.bit_n == OVH_BIT);
  endfunction

endpackage

// file: rtl/dom_rx_bit_if.sv
`timescale 1ns/10ps
`default_nettype none

interface dom_rx_bit_if;
  logic bit_valid;
  logic bit_data;
  modport src(output bit_valid, output bit_data);
  modport dst(input bit_valid, input bit_data);
endinterface

`default_nettype wire

// file: rtl/dom_rx_sampler.sv
`timescale 1ns/10ps
`default_nettype none

module dom_rx_sampler
  import dom_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Line pins
  input wire logic line_rx_clock,
  input wire logic line_rx_data,
  input wire logic line_rx_neg_rail,
  // Configuration
  input wire logic cfg_rx_fall_edge,
  input wire logic cfg_rx_dual_rail,
  // Recovered bits
  dom_rx_bit_if.src rx_bits
);

  logic [2:0] clk_sync_q;
  logic [1:0] pos_sync_q;
  logic [1:0] neg_sync_q;
  logic last_pos_q;
  logic [1:0] hist_q;
  logic valid_q;
  logic data_q;
  logic line_edge;
  logic pulse;
  logic viol;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clk_sync_q <= 3'h0;
      pos_sync_q <= 2'h0;
      neg_sync_q <= 2'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], line_rx_clock};
      pos_sync_q <= {pos_sync_q[0], line_rx_data};
      neg_sync_q <= {neg_sync_q[0], line_rx_neg_rail};
    end
  end

  // Data has the same sync delay as the clock, so it is stable here
  assign line_edge = cfg_rx_fall_edge ? (~clk_sync_q[1] & clk_sync_q[2])
                                      : (clk_sync_q[1] & ~clk_sync_q[2]);
  assign pulse = pos_sync_q[1] | neg_sync_q[1];
  assign viol = (pos_sync_q[1] & last_pos_q) |
                (neg_sync_q[1] & ~last_pos_q);

  // Bipolar violation marks B0V or 00V; both decode to three zeros
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      last_pos_q <= 1'b0;
      hist_q <= 2'h0;
      data_q <= 1'b0;
    end else if (line_edge) begin
      if (cfg_rx_dual_rail) begin
        data_q <= viol ? 1'b0 : hist_q[1];
        hist_q <= viol ? 2'h0 : {hist_q[0], pulse};
        if (pulse) begin
          last_pos_q <= pos_sync_q[1];
        end
      end else begin
        data_q <= pos_sync_q[1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= line_edge;
    end
  end

  assign rx_bits.bit_valid = valid_q;
  assign rx_bits.bit_data = data_q;

endmodule

`default_nettype wire

// file: sim/dom_access_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module dom_access_port_asserts (
  // Clock, reset, mode
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_m13_async,
  // Transmit pins
  input wire logic tx_bit_strobe,
  input wire logic tx_ovh_bit_clock,
  input wire logic tx_ovh_frame_sync_o,
  input wire logic tx_stuff_bit_clock,
  // Receive pins
  input wire logic rx_bit_valid,
  input wire logic rx_ovh_bit_clock,
  input wire logic rx_ovh_data_out,
  input wire logic rx_ovh_frame_sync,
  input wire logic rx_stuff_bit_clock,
  input wire logic rx_stuff_bit_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_ock;
    $changed(tx_ovh_bit_clock) |-> $past(tx_bit_strobe); endproperty
  a_ock: assert property (p_ock)
    else $error("tx ovh clock moved without strobe");
  property p_sck;
    $rose(tx_stuff_bit_clock) |-> $rose(tx_ovh_bit_clock); endproperty
  a_sck: assert property (p_sck)
    else $error("tx stuff clock rose off slot");
  property p_tsy;
    $changed(tx_ovh_frame_sync_o) |-> $fell(tx_ovh_bit_clock); endproperty
  a_tsy: assert property (p_tsy)
    else $error("tx sync moved off falling edge");
  // Three cycles give the registered clocks time to settle
  property p_nost;
    !cfg_m13_async [*3] |-> !tx_stuff_bit_clock && !rx_stuff_bit_clock
      && !rx_stuff_bit_data; endproperty
  a_nost: assert property (p_nost)
    else $error("stuff pins active outside M13");
  property p_rck;
    $fell(rx_ovh_bit_clock) |-> $past(rx_bit_valid); endproperty
  a_rck: assert property (p_rck)
    else $error("rx ovh clock fell without bit");
  property p_rdat;
    $changed(rx_ovh_data_out) |-> $fell(rx_ovh_bit_clock); endproperty
  a_rdat: assert property (p_rdat)
    else $error("rx ovh data moved off edge");
  property p_rsy;
    $changed(rx_ovh_frame_sync) |-> $fell(rx_ovh_bit_clock); endproperty
  a_rsy: assert property (p_rsy)
    else $error("rx sync moved off edge");
  property p_rsd;
    $changed(rx_stuff_bit_data) |-> $fell(rx_stuff_bit_clock); endproperty
  a_rsd: assert property (p_rsd)
    else $error("rx stuff data moved off edge");
endmodule
`default_nettype wire

// file: sim/dom_ovh_partner.sv
`timescale 1ns/10ps
`default_nettype none
module dom_ovh_partner (
  // Clocks from the port
  input wire logic ovh_clk,
  input wire logic stuff_clk,
  // Bench asks for a frame mark
  input wire logic sync_go,
  // Pins to the port
  output logic ovh_d,
  output logic ovh_en,
  output logic stuff_d,
  output logic sync_pin
);
  logic [2:0] cnt;
  initial begin
    {cnt, ovh_d, ovh_en, stuff_d} = '0;
  end
  // New bit after the fall, so it is stable long before the rise
  always @(negedge ovh_clk) begin
    cnt <= cnt + 3'h1;
    ovh_d <= cnt[0] ^ cnt[2];
    ovh_en <= cnt[0] ^ cnt[1];
  end
  always @(negedge stuff_clk) begin
    stuff_d <= !stuff_d;
  end
  // Held only while asked, so the port sees a single rising edge
  assign sync_pin = sync_go;
endmodule
`default_nettype wire

// file: sim/tb_dom_access_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dom_access_port;
  import dom_pkg::*;
  localparam int LIMIT = 60000;
  localparam int SF = BLOCK_BITS * BLOCKS;
  localparam int MF = SF * SUBFRAMES;
  logic core_clk = 1'b0, resetn = 1'b0;
  logic fe = 1'b0, dr = 1'b0, si = 1'b0, m13 = 1'b0, ins = 1'b0;
  logic lck = 1'b0, ld = 1'b0, ln = 1'b0, stb = 1'b0, ib = 1'b0;
  logic go = 1'b0, rok = 1'b0, rsk = 1'b0;
  logic p_d, p_en, p_s, p_sy, cd, ce, cs;
  logic t_ock, t_syo, t_oe, t_sck, t_o, t_v, t_ms;
  logic r_ock, r_od, r_sy, r_sck, r_sd, r_v, r_d;
  logic rxq[$], stq[$];
  logic [1:0] ovq[$];
  int mismatches = 0, n_tests = 0, cyc = 0, n;
  wire logic sy_pin;
  // Shared sync pin: whoever has it enabled sets the level
  assign sy_pin = t_oe ? t_syo : p_sy;
  dom_access_port dut (
    .core_clk(core_clk), .resetn(resetn),
    .line_rx_clock(lck), .line_rx_data(ld), .line_rx_neg_rail(ln),
    .cfg_rx_fall_edge(fe), .cfg_rx_dual_rail(dr),
    .cfg_tx_sync_input(si), .cfg_m13_async(m13),
    .cfg_tx_stuff_insert(ins), .tx_ovh_bit_clock(t_ock),
    .tx_ovh_data_in(p_d), .tx_ovh_insert_enable(p_en),
    .tx_ovh_frame_sync_i(sy_pin), .tx_ovh_frame_sync_o(t_syo),
    .tx_ovh_frame_sync_oe(t_oe), .tx_stuff_bit_clock(t_sck),
    .tx_stuff_bit_data(p_s), .rx_ovh_bit_clock(r_ock),
    .rx_ovh_data_out(r_od), .rx_ovh_frame_sync(r_sy),
    .rx_stuff_bit_clock(r_sck), .rx_stuff_bit_data(r_sd),
    .tx_bit_strobe(stb), .tx_bit_internal(ib), .tx_bit_out(t_o),
    .tx_bit_out_valid(t_v), .tx_mframe_start(t_ms), .rx_bit_valid(r_v),
    .rx_bit_data(r_d), .rx_mframe_align(1'b0), .rx_mframe_start()
  );
  dom_ovh_partner partner (
    .ovh_clk(t_ock), .stuff_clk(t_sck), .sync_go(go),
    .ovh_d(p_d), .ovh_en(p_en), .stuff_d(p_s), .sync_pin(p_sy)
  );
  always #2 core_clk = !core_clk;
  function automatic logic pat(input int k);
    return k[0] ^ k[3] ^ k[6];
  endfunction
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [4:0] c);
    @(negedge core_clk);
    resetn = 1'b0;
    {fe, dr, si, m13, ins} = c;
    lck = c[4];
    n = 0;
    ce = 1'b0;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    chk(t_oe, !si);
  endtask
  task automatic strobe;
    int b, k, s;
    logic e;
    b = n % BLOCK_BITS;
    k = (n / BLOCK_BITS) % BLOCKS;
    s = (n / SF) % SUBFRAMES;
    e = n[0] ^ n[3];
    ib = e;
    stb = 1'b1;
    if (b == 0 && ce) e = cd;
    if (k == 7 && b == 1 && m13 && ins) e = cs;
    @(negedge core_clk);
    stb = 1'b0;
    chk(t_v, 1'b1);
    chk(t_o, e);
    chk(t_ms, n % MF == 0);
    chk(t_ock, b >= OVH_CLK_RISE);
    chk(t_sck, m13 && k == 6 && b >= OVH_CLK_RISE);
    if (!si) chk(t_syo, s == 6 && k == 7);
    if (b == OVH_CLK_RISE) {cd, ce} = {p_d, p_en};
    if (k == 6 && b == OVH_CLK_RISE) cs = p_s;
    n++;
    @(negedge core_clk);
  endtask
  // Line clock is free of the core clock; data moves a quarter bit early
  task automatic rx_run(input int nb);
    logic pol;
    pol = 1'b0;
    rxq.delete();
    ovq.delete();
    stq.delete();
    #1.3;
    for (int k = 0; k < nb; k++) begin
      ld = dr ? pat(k) & !pol : pat(k);
      ln = dr ? pat(k) & pol : !pat(k);
      pol = pol ^ pat(k);
      #12 lck = !lck;
      #24 lck = !lck;
      #12;
    end
    repeat (8) @(negedge core_clk);
    chk(rxq.size() == nb, 1'b1);
    for (int k = dr ? 6 : 0; k < nb; k++) begin
      chk(rxq[k], pat(dr ? k - 2 : k));
    end
    if (!dr) begin
      chk(ovq.size() == (nb - 2) / BLOCK_BITS + 1, 1'b1);
      foreach (ovq[j]) begin
        chk(ovq[j], {j == 0, pat(j * BLOCK_BITS)});
      end
    end
    if (m13) chk(stq[0], pat(STUFF_BLK * BLOCK_BITS + 1));
    $display("test rx done");
  endtask
  always @(negedge core_clk) begin
    if (r_v === 1'b1) rxq.push_back(r_d);
    if (rok && !r_ock) ovq.push_back({r_sy, r_od});
    if (rsk && !r_sck) stq.push_back(r_sd);
    rok = r_ock;
    rsk = r_sck;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    do_reset(5'h03);
    repeat (4845) strobe();
    $display("test tx insert done");
    do_reset(5'h01);
    repeat (700) strobe();
    $display("test tx no m13 done");
    do_reset(5'h04);
    repeat (50) strobe();
    go = 1'b1;
    repeat (6) @(negedge core_clk);
    n = 0;
    repeat (100) strobe();
    go = 1'b0;
    $display("test tx sync input done");
    do_reset(5'h02);
    rx_run(700);
    do_reset(5'h10);
    rx_run(120);
    do_reset(5'h18);
    rx_run(120);
    do_reset(5'h08);
    rx_run(120);
    print_verdict();
  end
endmodule
bind dom_access_port dom_access_port_asserts u_chk (
  .core_clk(core_clk), .resetn(resetn), .cfg_m13_async(cfg_m13_async),
  .tx_bit_strobe(tx_bit_strobe), .tx_ovh_bit_clock(tx_ovh_bit_clock),
  .tx_ovh_frame_sync_o(tx_ovh_frame_sync_o),
  .tx_stuff_bit_clock(tx_stuff_bit_clock), .rx_bit_valid(rx_bit_valid),
  .rx_ovh_bit_clock(rx_ovh_bit_clock), .rx_ovh_data_out(rx_ovh_data_out),
  .rx_ovh_frame_sync(rx_ovh_frame_sync),
  .rx_stuff_bit_clock(rx_stuff_bit_clock),
  .rx_stuff_bit_data(rx_stuff_bit_data)
);
`default_nettype wire
